/* File: dp_float_pass_scale_fix_alu.v */
// double-precision pass, scale and float-to-integer alu with apb status registers
`include "dp_alu_defs.vh"

module dp_float_pass_scale_fix_alu
(
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // operation request from the sequencer
  input  wire        op_valid_i,
  input  wire [2:0]  op_code_i,
  input  wire [63:0] src_float_pair_i,
  input  wire [31:0] scale_int_reg_i,
  output reg         op_ready_o,
  // result to the register file
  output reg         result_valid_o,
  output reg         result_is_int_o,
  output reg  [63:0] dest_float_pair_o,
  output reg  [39:0] dest_int_reg_o,
  // status views
  output reg  [5:0]  arith_status_o,
  output reg  [3:0]  sticky_status_o,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o
);

  // operation latch, countdown and apb mode register
  reg  [2:0]  op_reg;
  reg  [63:0] src_reg;
  reg  [31:0] scale_reg;
  reg  [2:0]  mode_snap_reg;
  reg  [2:0]  cnt_reg;
  reg  [2:0]  mode_control_reg;

  // apb decode terms, request take and finish
  wire        apb_setup;
  wire        apb_access;
  wire        hit_mode;
  wire        hit_arith;
  wire        hit_sticky;
  wire        take;
  wire        finish;

  // operand fields, denormals already folded to zero
  wire        sgn;
  wire [10:0] exp_f;
  wire [51:0] man_f;
  wire        is_nan;
  wire        is_inf;
  wire        is_zero;
  wire [63:0] flushed;
  wire [33:0] scale_ext;
  wire        trunc_bit;
  wire        sat_bit;
  wire        width_bit;

  // combinational results
  reg  [63:0] flt_res;
  reg  [39:0] int_res;
  reg         res_int;
  reg  [5:0]  ast_next;
  reg  [3:0]  stk_set;

  // scale and conversion working values
  reg  [33:0] biased_new;
  reg  [33:0] unb_exp;
  reg  [33:0] sh;
  reg  [52:0] mant;
  reg  [52:0] mask;
  reg  [52:0] shifted;
  reg  [31:0] ip;
  reg         half;
  reg         below;
  reg         frac_nz;
  reg         inc;
  reg  [32:0] mag;
  reg  [31:0] ival;
  reg         pre_out;
  reg         ovf;
  reg         udf;
  reg         neg_inf_mode;

  assign apb_setup  = psel_i & ~penable_i;
  assign apb_access = psel_i & penable_i & pready_o;
  assign hit_mode   = (paddr_i == `MODE_CONTROL_OFS);
  assign hit_arith  = (paddr_i == `ARITH_STATUS_OFS);
  assign hit_sticky = (paddr_i == `STICKY_STATUS_OFS);
  assign take       = op_valid_i & op_ready_o;
  assign finish     = ~op_ready_o & (cnt_reg == 3'h1);

  // a denormal has a zero biased exponent, so clearing the fraction flushes it
  assign sgn       = src_reg[63];
  assign exp_f     = src_reg[62:52];
  assign man_f     = (exp_f == 11'h000) ? 52'h0 : src_reg[51:0];
  assign is_nan    = (exp_f == `EXP_ALL_ONES) & (src_reg[51:0] != 52'h0);
  assign is_inf    = (exp_f == `EXP_ALL_ONES) & (src_reg[51:0] == 52'h0);
  assign is_zero   = (exp_f == 11'h000);
  assign flushed   = {sgn, exp_f, man_f};
  assign scale_ext = {{2{scale_reg[31]}}, scale_reg};
  assign trunc_bit = mode_snap_reg[`MODE_TRUNCATE_BIT];
  assign sat_bit   = mode_snap_reg[`MODE_SATURATE_BIT];
  assign width_bit = mode_snap_reg[`MODE_ROUND_WIDTH_BIT];

  // operation datapath; mode bits are sampled when the request is taken
  always @*
  begin
    flt_res      = 64'h0;
    int_res      = 40'h0;
    res_int      = 1'b0;
    ast_next     = `ARITH_RESET;
    stk_set      = `STICKY_RESET;
    biased_new   = {23'h0, exp_f} + scale_ext;
    unb_exp      = {23'h0, exp_f} - `EXP_BIAS
                   + ((op_reg == `OP_FIX_BY) ? scale_ext : 34'h0);
    sh           = 34'h0;
    shifted      = 53'h0;
    mant         = {1'b1, man_f};
    mask         = 53'h0;
    ip           = 32'h0;
    half         = 1'b0;
    below        = 1'b0;
    frac_nz      = 1'b0;
    inc          = 1'b0;
    mag          = 33'h0;
    ival         = 32'h0;
    pre_out      = 1'b0;
    ovf          = 1'b0;
    udf          = 1'b0;
    neg_inf_mode = (op_reg != `OP_TRUNC) & trunc_bit;
    case (op_reg)
      `OP_PASS:
      begin
        flt_res = is_nan ? {64{1'b1}} : flushed;
        ast_next[`AST_INVALID_BIT]  = is_nan;
        ast_next[`AST_NEGATIVE_BIT] = sgn & ~is_nan;
        ast_next[`AST_ZERO_BIT]     = is_zero;
        stk_set[`STK_INVALID_BIT]   = is_nan;
      end
      `OP_SCALE:
      begin
        // scaling by a power of two is exact; rounding only shapes overflow
        if (is_nan)
          flt_res = {64{1'b1}};
        else if (is_inf)
          flt_res = flushed;
        else if (is_zero)
          flt_res = flushed;
        else if ($signed(biased_new) > $signed(`EXP_MAX_BIASED))
        begin
          ovf     = 1'b1;
          flt_res = trunc_bit ? {sgn, `LARGEST_NORMAL_MAG}
                              : {sgn, `EXP_ALL_ONES, 52'h0};
        end
        else if ($signed(biased_new) < $signed(34'h1))
        begin
          udf     = 1'b1;
          flt_res = {sgn, 63'h0};
        end
        else
          flt_res = {sgn, biased_new[10:0], man_f};
        ast_next[`AST_INVALID_BIT]  = is_nan;
        ast_next[`AST_NEGATIVE_BIT] = flt_res[63] & ~is_nan;
        ast_next[`AST_OVERFLOW_BIT] = ovf;
        ast_next[`AST_ZERO_BIT]     = (udf | is_zero) & ~is_nan;
        stk_set[`STK_UNDERFLOW_BIT] = udf;
        stk_set[`STK_OVERFLOW_BIT]  = ovf;
        stk_set[`STK_INVALID_BIT]   = is_nan;
      end
      `OP_FIX, `OP_FIX_BY, `OP_TRUNC:
      begin
        res_int = 1'b1;
        // split the magnitude into integer part, half bit and sticky remainder
        if (is_zero)
          mag = 33'h0;
        else if ($signed(unb_exp) >= $signed(`INT_MSB_EXP))
        begin
          // only exactly minus two to the 31 fits at this exponent
          pre_out = ~(sgn & (unb_exp == `INT_MSB_EXP) & (man_f == 52'h0));
          mag     = 33'h080000000;
        end
        else
        begin
          if ($signed(unb_exp) < $signed(34'h3ffffffff))
          begin
            frac_nz = 1'b1;
          end
          else
          begin
            sh      = `MANT_FRAC_BITS - unb_exp;
            mask    = ~({53{1'b1}} << sh);
            // keep one bit below the point so the half bit comes along
            shifted = mant >> (sh - 34'h1);
            ip      = shifted[32:1];
            half    = shifted[0];
            below   = |(mant & (mask >> 1));
            frac_nz = |(mant & mask);
          end
          if (op_reg == `OP_TRUNC)
            inc = 1'b0;
          else if (trunc_bit)
            inc = sgn & frac_nz;
          else
            inc = half & (below | ip[0]);
          mag = {1'b0, ip} + {32'h0, inc};
        end
        udf = ~is_zero & ~is_inf & ~is_nan & unb_exp[33];
        ovf = pre_out | (~sgn & mag[31]) | (sgn & (mag > 33'h080000000));
        ival = sgn ? (~mag[31:0] + 32'h1) : mag[31:0];
        if (udf & ~(sgn & neg_inf_mode))
          ival = 32'h0;
        else if (udf)
          ival = `INT_MINUS_ONE;
        // special values replace the integer result
        if (is_nan)
          int_res = width_bit ? `ONES_NARROW : `ONES_WIDE;
        else if ((is_inf | ovf) & sat_bit)
          int_res = {(sgn ? `INT_NEG_SAT : `INT_POS_SAT), 8'h00};
        else if (is_inf | ovf)
          int_res = width_bit ? `ONES_NARROW : `ONES_WIDE;
        else
          int_res = {ival, 8'h00};
        ast_next[`AST_INVALID_BIT]  = is_nan | (~sat_bit & (is_inf | ovf));
        ast_next[`AST_OVERFLOW_BIT] = ~is_nan & (pre_out | is_inf);
        ast_next[`AST_ZERO_BIT]     = ~is_nan & ~is_inf & ~ovf & (ival == 32'h0);
        ast_next[`AST_NEGATIVE_BIT] = ~is_nan & ~is_inf & ~ovf & ival[31];
        if (~is_nan & (is_inf | ovf) & sat_bit)
          ast_next[`AST_NEGATIVE_BIT] = sgn;
        stk_set[`STK_INVALID_BIT]   = ast_next[`AST_INVALID_BIT];
        stk_set[`STK_OVERFLOW_BIT]  = ast_next[`AST_OVERFLOW_BIT];
        stk_set[`STK_UNDERFLOW_BIT] = udf;
      end
      default:
      begin
        flt_res = flushed;
      end
    endcase
  end

  // request capture and latency countdown; one operation in flight
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      op_reg        <= `OP_PASS;
      src_reg       <= 64'h0;
      scale_reg     <= 32'h0;
      mode_snap_reg <= `MODE_RESET;
      cnt_reg       <= 3'h0;
      op_ready_o    <= 1'b1;
    end
    else if (take)
    begin
      op_reg        <= op_code_i;
      src_reg       <= src_float_pair_i;
      scale_reg     <= scale_int_reg_i;
      mode_snap_reg <= mode_control_reg;
      op_ready_o    <= 1'b0;
      if ((op_code_i == `OP_PASS) | (op_code_i == `OP_SCALE))
        cnt_reg <= `LAT_SHORT;
      else
        cnt_reg <= `LAT_LONG;
    end
    else if (finish)
    begin
      cnt_reg    <= 3'h0;
      op_ready_o <= 1'b1;
    end
    else if (~op_ready_o)
    begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // destination write at the end of the last execution cycle
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_valid_o    <= 1'b0;
      result_is_int_o   <= 1'b0;
      dest_float_pair_o <= 64'h0;
      dest_int_reg_o    <= 40'h0;
    end
    else
    begin
      result_valid_o <= finish;
      if (finish)
      begin
        result_is_int_o <= res_int;
        if (res_int)
          dest_int_reg_o <= int_res;
        else
          dest_float_pair_o <= flt_res;
      end
    end
  end

  // status update; this instance serves one element, so its copies stay private
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      arith_status_o  <= `ARITH_RESET;
      sticky_status_o <= `STICKY_RESET;
    end
    else
    begin
      if (finish)
        arith_status_o <= ast_next;
      // a set arriving with a software clear wins; untouched bits hold
      if (apb_access & pwrite_i & hit_sticky)
        sticky_status_o <= (sticky_status_o & ~pwdata_i[3:0])
                           | (finish ? stk_set : 4'h0);
      else if (finish)
        sticky_status_o <= sticky_status_o | stk_set;
    end
  end

  // apb slave: no wait state; pready and prdata come from flops loaded in the setup phase
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_control_reg <= `MODE_RESET;
      prdata_o         <= 32'h0;
      pready_o         <= 1'b0;
      pslverr_o        <= 1'b0;
    end
    else
    begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~(hit_mode | hit_arith | hit_sticky);
      if (apb_setup & ~pwrite_i)
      begin
        if (hit_mode)
          prdata_o <= {29'h0, mode_control_reg};
        else if (hit_arith)
          prdata_o <= {26'h0, arith_status_o};
        else if (hit_sticky)
          prdata_o <= {28'h0, sticky_status_o};
        else
          prdata_o <= 32'h0;
      end
      else if (apb_setup)
      begin
        prdata_o <= 32'h0;
      end
      if (apb_access & pwrite_i & hit_mode)
        mode_control_reg <= pwdata_i[2:0];
    end
  end

endmodule // dp_float_pass_scale_fix_alu

/* File: dp_alu_defs.vh */
// constants for the double-precision pass, scale and convert alu block
`ifndef DP_ALU_DEFS_VH
`define DP_ALU_DEFS_VH

// apb register byte offsets
`define MODE_CONTROL_OFS     8'h00
`define ARITH_STATUS_OFS     8'h04
`define STICKY_STATUS_OFS    8'h08

// mode control field positions and reset value
`define MODE_TRUNCATE_BIT    0
`define MODE_SATURATE_BIT    1
`define MODE_ROUND_WIDTH_BIT 2
`define MODE_RESET           3'h0

// arithmetic status field positions
`define AST_ZERO_BIT         0
`define AST_OVERFLOW_BIT     1
`define AST_NEGATIVE_BIT     2
`define AST_CARRY_BIT        3
`define AST_SIGN_INPUT_BIT   4
`define AST_INVALID_BIT      5
`define ARITH_RESET          6'h00

// sticky status field positions
`define STK_UNDERFLOW_BIT    0
`define STK_OVERFLOW_BIT     1
`define STK_FIXED_OVF_BIT    2
`define STK_INVALID_BIT      3
`define STICKY_RESET         4'h0

// operation codes
`define OP_PASS              3'h0
`define OP_SCALE             3'h1
`define OP_FIX               3'h2
`define OP_FIX_BY            3'h3
`define OP_TRUNC             3'h4

// latencies in execution cycles
`define LAT_SHORT            3'h2
`define LAT_LONG             3'h4

// double-precision constants
`define EXP_ALL_ONES         11'h7ff
`define EXP_BIAS             34'h0000003ff
`define EXP_MAX_BIASED       34'h0000007fe
`define MANT_FRAC_BITS       34'h000000034
`define INT_MSB_EXP          34'h00000001f
`define LARGEST_NORMAL_MAG   63'h7fefffffffffffff

// integer conversion results
`define INT_POS_SAT          32'h7fffffff
`define INT_NEG_SAT          32'h80000000
`define INT_MINUS_ONE        32'hffffffff
`define ONES_NARROW          40'h00ffffffff
`define ONES_WIDE            40'h0fffffffff

`endif

/* File: alu_chk.sv */
// port checker for the double-precision alu block
`include "dp_alu_defs.vh"
module alu_chk
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // operation side
  input wire logic        op_valid_i,
  input wire logic [2:0]  op_code_i,
  input wire logic        op_ready_o,
  input wire logic        result_valid_o,
  input wire logic        result_is_int_o,
  input wire logic [63:0] dest_float_pair_o,
  input wire logic [39:0] dest_int_reg_o,
  input wire logic [5:0]  arith_status_o,
  input wire logic [3:0]  sticky_status_o,
  // apb side
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // take, latency class and result kinds
  wire take = op_valid_i & op_ready_o;
  wire lng  = ~((op_code_i == `OP_PASS) | (op_code_i == `OP_SCALE));
  wire fin  = result_valid_o;
  wire fint = result_valid_o & result_is_int_o;
  // sticky may also change through a completed clear write
  wire stkw = psel_i & penable_i & pwrite_i & pready_o & (paddr_i == `STICKY_STATUS_OFS);
  AST_SHORT_LAT: assert property (take && !lng |=> !fin [*2] ##1 fin)
    else $error("short op latency wrong");
  AST_LONG_LAT: assert property (take && lng |=> !fin [*4] ##1 fin)
    else $error("conversion latency wrong");
  AST_EXT_ZERO: assert property (fint && !arith_status_o[`AST_INVALID_BIT] |->
    dest_int_reg_o[7:0] == 8'h00)
    else $error("extension field not zero");
  AST_CONV_CLR: assert property (fint |-> !arith_status_o[`AST_CARRY_BIT] &&
    !arith_status_o[`AST_SIGN_INPUT_BIT]) else $error("carry or sign flag set");
  AST_INT_ZERO: assert property (fint && dest_int_reg_o[39:8] == 32'h0 |->
    arith_status_o[`AST_ZERO_BIT]) else $error("zero flag missing");
  AST_INT_NEG: assert property (fint && dest_int_reg_o[39] |->
    arith_status_o[`AST_NEGATIVE_BIT]) else $error("negative flag missing");
  AST_NAN_ONES: assert property (fin && !result_is_int_o && (&dest_float_pair_o) |->
    arith_status_o[`AST_INVALID_BIT]) else $error("ones result without invalid");
  AST_INV_STK: assert property (fin && arith_status_o[`AST_INVALID_BIT] |->
    sticky_status_o[`STK_INVALID_BIT]) else $error("invalid sticky not set");
  AST_OVF_STK: assert property (fin && arith_status_o[`AST_OVERFLOW_BIT] |->
    sticky_status_o[`STK_OVERFLOW_BIT]) else $error("overflow sticky not set");
  AST_ARITH_HOLD: assert property ($changed(arith_status_o) |-> fin)
    else $error("status changed without result");
  AST_STK_HOLD: assert property ($changed(sticky_status_o) |-> fin || $past(stkw))
    else $error("sticky changed without cause");
  AST_PULSE: assert property (fin |=> !fin)
    else $error("result strobe too long");
  // main scenarios
  cover property (take && lng);
  cover property (fint && dest_int_reg_o[39]);
  cover property (stkw);
endmodule // alu_chk

/* File: op_source.sv */
// sequencer model that issues operations and waits for results
module op_source
(
  // clock and handshake
  input  wire logic        clk_i,
  input  wire logic        op_ready_o,
  input  wire logic        result_valid_o,
  // request
  output logic             op_valid_i,
  output logic [2:0]       op_code_i,
  output logic [63:0]      src_float_pair_i,
  output logic [31:0]      scale_int_reg_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat;
  // idle request lines at time zero
  initial {op_valid_i, op_code_i, src_float_pair_i, scale_int_reg_i} = '0;
  // hold until taken, then scramble operands so stale values are not reused
  task issue(input logic [2:0] c, input logic [63:0] s, input logic [31:0] k);
    @(posedge clk_i);
    {op_valid_i, op_code_i, src_float_pair_i, scale_int_reg_i} <= {1'b1, c, s, k};
    do @(posedge clk_i); while (op_ready_o !== 1'b1);
    {op_valid_i, src_float_pair_i, scale_int_reg_i} <= {1'b0, ~s, ~k};
    lat = 0;
    do
    begin
      @(posedge clk_i);
      lat++;
    end
    while (result_valid_o !== 1'b1);
  endtask
endmodule // op_source

/* File: tb.sv */
// self-checking bench for the double-precision alu block
`include "dp_alu_defs.vh"
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // design connections
  logic        clk_i, reset_i, op_valid_i, op_ready_o, result_valid_o, result_is_int_o;
  logic [2:0]  op_code_i;
  logic [63:0] src_float_pair_i, dest_float_pair_o;
  logic [31:0] scale_int_reg_i, pwdata_i, prdata_o, rd;
  logic [39:0] dest_int_reg_o;
  logic [5:0]  arith_status_o;
  logic [3:0]  sticky_status_o;
  logic [7:0]  paddr_i;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  int          fail_count, num_checks;
  // operand values
  localparam logic [63:0] ONE = 64'h3ff0000000000000, P25 = 64'h4004000000000000;
  localparam logic [63:0] M25 = 64'hc004000000000000, MH = 64'hbfe0000000000000;
  localparam logic [63:0] NAN = 64'h7ff8000000000000, PINF = 64'h7ff0000000000000;
  localparam logic [63:0] MINF = 64'hfff0000000000000;
  dp_float_pass_scale_fix_alu dut (.clk_i, .reset_i, .op_valid_i, .op_code_i,
    .src_float_pair_i, .scale_int_reg_i, .op_ready_o, .result_valid_o, .result_is_int_o,
    .dest_float_pair_o, .dest_int_reg_o, .arith_status_o, .sticky_status_o, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
  op_source seq (.clk_i, .op_ready_o, .result_valid_o, .op_valid_i, .op_code_i,
    .src_float_pair_i, .scale_int_reg_i);
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // apb master: setup, access held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task md(input logic [2:0] m);
    apb(1'b1, `MODE_CONTROL_OFS, {29'h0, m});
  endtask
  task clr;
    apb(1'b1, `STICKY_STATUS_OFS, 32'hf);
  endtask
  task cf(input string n, input logic [63:0] e, input logic [5:0] a);
    `CK(n, e, dest_float_pair_o)
    `CK(n, a, arith_status_o)
  endtask
  task ci(input string n, input logic [39:0] e, input logic [5:0] a);
    `CK(n, e, dest_int_reg_o)
    `CK(n, a, arith_status_o)
    `CK(n, 1'b1, result_is_int_o)
  endtask
  // reset values, read-only status, unmapped place
  task t_regs;
    apb(1'b0, `MODE_CONTROL_OFS, 32'h0);
    `CK("mode rst", 32'h0, rd)
    apb(1'b1, `ARITH_STATUS_OFS, 32'h3f);
    apb(1'b0, `ARITH_STATUS_OFS, 32'h0);
    `CK("arith ro", 32'h0, rd)
    apb(1'b0, 8'hfc, 32'h0);
    `CK("unmapped err", 1'b1, er)
    `CK("unmapped data", 32'h0, rd)
    md(3'h7);
    apb(1'b0, `MODE_CONTROL_OFS, 32'h0);
    `CK("mode rw", 32'h7, rd)
    md(3'h0);
    $display("test regs done");
  endtask
  // pass: copy, denormal flush, nan
  task t_pass;
    clr;
    seq.issue(`OP_PASS, P25, 32'h0);
    cf("pass", P25, 6'h00);
    `CK("pass lat", 3, seq.lat)
    seq.issue(`OP_PASS, 64'h8000000000000001, 32'h0);
    cf("pass denorm", 64'h8000000000000000, 6'h05);
    seq.issue(`OP_PASS, NAN, 32'h0);
    cf("pass nan", {64{1'b1}}, 6'h20);
    `CK("pass stk", 4'h8, sticky_status_o)
    $display("test pass done");
  endtask
  // scale: plain, overflow both modes, underflow, infinity
  task t_scale;
    clr;
    seq.issue(`OP_SCALE, ONE, 32'h3);
    cf("scale", 64'h4020000000000000, 6'h00);
    seq.issue(`OP_SCALE, ONE, 32'h400);
    cf("scale ovf rn", PINF, 6'h02);
    md(3'h1);
    seq.issue(`OP_SCALE, 64'hbff0000000000000, 32'h400);
    cf("scale ovf rz", 64'hffefffffffffffff, 6'h06);
    seq.issue(`OP_SCALE, ONE, 32'hfffffc01);
    cf("scale unf", 64'h0, 6'h01);
    `CK("scale stk", 4'h3, sticky_status_o)
    seq.issue(`OP_SCALE, MINF, 32'hfffffffb);
    `CK("scale inf", MINF, dest_float_pair_o)
    md(3'h0);
    $display("test scale done");
  endtask
  // conversions: rounding modes, underflow, nan widths
  task t_fix;
    clr;
    seq.issue(`OP_FIX, P25, 32'h0);
    ci("fix rn", 40'h0000000200, 6'h00);
    `CK("fix lat", 5, seq.lat)
    seq.issue(`OP_FIX, M25, 32'h0);
    ci("fix rn neg", 40'hfffffffe00, 6'h04);
    seq.issue(`OP_FIX, MH, 32'h0);
    ci("fix unf rn", 40'h0, 6'h01);
    `CK("fix unf stk", 4'h1, sticky_status_o)
    md(3'h1);
    seq.issue(`OP_FIX, M25, 32'h0);
    ci("fix rm", 40'hfffffffd00, 6'h04);
    seq.issue(`OP_FIX, MH, 32'h0);
    ci("fix unf rm", 40'hffffffff00, 6'h04);
    seq.issue(`OP_TRUNC, M25, 32'h0);
    ci("trunc", 40'hfffffffe00, 6'h04);
    seq.issue(`OP_FIX_BY, ONE, 32'h4);
    ci("fix by", 40'h0000001000, 6'h00);
    md(3'h4);
    seq.issue(`OP_FIX, NAN, 32'h0);
    ci("nan narrow", `ONES_NARROW, 6'h20);
    md(3'h0);
    seq.issue(`OP_TRUNC, NAN, 32'h0);
    ci("nan wide", `ONES_WIDE, 6'h20);
    $display("test fix done");
  endtask
  // saturation on and off, then sticky clear
  task t_sat;
    md(3'h2);
    clr;
    seq.issue(`OP_FIX, 64'h41f0000000000000, 32'h0);
    ci("sat pos", 40'h7fffffff00, 6'h02);
    seq.issue(`OP_TRUNC, MINF, 32'h0);
    ci("sat ninf", 40'h8000000000, 6'h06);
    `CK("sat stk", 4'h2, sticky_status_o)
    md(3'h4);
    seq.issue(`OP_FIX, PINF, 32'h0);
    ci("nosat inf", `ONES_NARROW, 6'h22);
    `CK("nosat stk", 4'ha, sticky_status_o)
    clr;
    apb(1'b0, `STICKY_STATUS_OFS, 32'h0);
    `CK("stk clear", 32'h0, rd)
    $display("test sat done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence after a ten-cycle reset
  initial
  begin
    {fail_count, num_checks} = '0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_pass;
    t_scale;
    t_fix;
    t_sat;
    wrap_up;
  end
  // watchdog well beyond the few hundred cycles needed
  initial
  begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule // tb
bind dp_float_pass_scale_fix_alu alu_chk chk (.clk_i, .reset_i, .op_valid_i, .op_code_i,
  .op_ready_o, .result_valid_o, .result_is_int_o, .dest_float_pair_o, .dest_int_reg_o,
  .arith_status_o, .sticky_status_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o);
